// File: design/ptpa_pkg.sv
// Purpose: Shared constants and types for the periodic tick and pulse accumulator block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Register fields sit in the low byte, except the 16-bit FRC count; upper bits read as zero.
package ptpa_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int unsigned PTPA_AW       = 8;
    localparam int unsigned PTPA_DW       = 32;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h00;
    localparam logic [7:0]  OFS_FLAGS     = 8'h04;
    localparam logic [7:0]  OFS_PULSE_ACCUM_CONTROL     = 8'h08;
    localparam logic [7:0]  OFS_COUNT     = 8'h0C;
    localparam logic [7:0]  OFS_FRC       = 8'h10;

    // ************************************************************
    // Field positions and masks
    // ************************************************************
    localparam int unsigned BIT_CNT_OVF   = 7;
    localparam int unsigned BIT_TICK      = 6;
    localparam int unsigned BIT_ACC_OVF   = 5;
    localparam int unsigned BIT_ACC_EDGE  = 4;
    localparam logic [7:0]  IRQ_EN_MASK   = 8'hF3;
    localparam logic [7:0]  FLAG_MASK     = 8'hF0;
    localparam logic [7:0]  IRQ_EN_RST    = 8'h00;
    localparam logic [3:0]  FLAGS_RST     = 4'h0;
    localparam logic [7:0]  PULSE_ACCUM_CONTROL_RST     = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    // Tick chain: full 16-bit mask is the 2^16 period, shifted down per rate code
    localparam logic [15:0] TICK_MAX_MASK = 16'hFFFF;
    localparam logic [1:0]  TICK_MAX_CODE = 2'h3;
    // Gated accumulation strobe: bus clock divided by 64
    localparam logic [5:0]  E64_MASK      = 6'h3F;
    // Prescaler write window after reset, in bus cycles
    localparam logic [6:0]  BOOT_WINDOW   = 7'h40;
    localparam logic [3:0]  PRESC_MASK_1  = 4'h0;
    localparam logic [3:0]  PRESC_MASK_4  = 4'h3;
    localparam logic [3:0]  PRESC_MASK_8  = 4'h7;
    localparam logic [3:0]  PRESC_MASK_16 = 4'hF;
    localparam logic [15:0] FRC_MAX       = 16'hFFFF;
    localparam logic [7:0]  COUNT_MAX     = 8'hFF;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       port_bit7_direction;
        logic       accum_enable;
        logic       accum_mode_select;
        logic       accum_edge_select;
        logic       port_bit3_direction;
        logic       capture_compare_share_select;
        logic [1:0] tick_rate_select;
    } ptpa_pulse_accum_control_t;

    typedef enum logic {
        APB_IDLE,
        APB_ACK
    } ptpa_apb_st_t;

endpackage

// File: design/ptpa_top.sv
// Purpose: Periodic tick generator, 8-bit pulse accumulator, free-running counter
//          and the shared enable/flag registers, reached over APB.
// Assumes: Single bus clock; accumulator input pin is asynchronous.
// Notes:   Accumulator count has no reset; software loads it before use.
//
// Local design decisions: the register addresses and the APB register port.

// Summary of operation
// - Tick base is bus clock over 2^13
// - Rate code adds divide by 1/2/4/8
// - Tick divider free-runs; stopped only by reset
// - Timeout sets tick flag; enable raises request
// - First tick flag after one full period
// - Tick flag bit 6, write-one clears
// - Flags clear only where one is written
// - Counter wrap to zero sets overflow flag
// - Upper enable bits gate matching flags
// - Enable bit on/off; mode event/gated
// - Event mode counts selected pin edge
// - Gated mode counts E/64 unless inhibited
// - Count always read/writable, kept through reset
// - Reads never see half-updated count
// - Count rollover sets overflow flag, bit 5
// - Overflow enable only gates request
// - Selected edge sets edge flag, bit 4
// - Edge enable only gates request
// - Share bit selects compare5 or capture4
// - Prescaler 1/4/8/16, write once in 64 outside special mode
module ptpa_top
    import ptpa_pkg::*;
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    // APB slave
    input  wire logic [ptpa_pkg::PTPA_AW-1:0] paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ptpa_pkg::PTPA_DW-1:0] pwdata,
    output logic      [ptpa_pkg::PTPA_DW-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Pins and mode straps
    input  wire logic                        accum_input_pin,
    input  wire logic                        special_mode,
    // Outputs to the rest of the timer
    output logic                             irq,
    output logic                             compare_channel_five_en,
    output logic                             capture_channel_four_en,
    output logic                             port_bit7_direction,
    output logic                             port_bit3_direction
);
    import ptpa_pkg::*;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    typedef struct packed {
        logic en;
        logic flg;
        logic ctl;
        logic cnt;
        logic frc;
    } ptpa_sel_t;

    function automatic ptpa_sel_t ptpa_decode(input logic [PTPA_AW-1:0] a);
        ptpa_sel_t s;
        s.en  = (a == OFS_IRQ_EN);
        s.flg = (a == OFS_FLAGS);
        s.ctl = (a == OFS_PULSE_ACCUM_CONTROL);
        s.cnt = (a == OFS_COUNT);
        s.frc = (a == OFS_FRC);
        return s;
    endfunction

    function automatic logic [15:0] ptpa_tick_mask(input logic [1:0] rate);
        return TICK_MAX_MASK >> (TICK_MAX_CODE - rate);
    endfunction

    function automatic logic [3:0] ptpa_presc_mask(input logic [1:0] pr);
        logic [3:0] m;
        m = PRESC_MASK_1;
        case (pr)
            2'h0:    m = PRESC_MASK_1;
            2'h1:    m = PRESC_MASK_4;
            2'h2:    m = PRESC_MASK_8;
            2'h3:    m = PRESC_MASK_16;
            default: m = PRESC_MASK_1;
        endcase
        return m;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    ptpa_apb_st_t          apb_st_q;
    logic [PTPA_DW-1:0]    prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic [7:0]            irq_en_q;
    logic [3:0]            flags_q;
    logic [3:0]            flags_d;
    ptpa_pulse_accum_control_t           pulse_accum_control_q;
    logic [7:0]            count_q;
    logic [15:0]           tick_div_q;
    logic [15:0]           frc_q;
    logic [6:0]            boot_cnt_q;
    logic                  pr_locked_q;
    logic                  pin_s1_q;
    logic                  pin_s2_q;
    logic                  pin_s3_q;
    logic                  pin_lvl_q;
    logic                  pin_prev_q;
    logic                  irq_q;
    logic                  cmp5_en_q;
    logic                  cap4_en_q;

    ptpa_sel_t             sel;
    logic                  wr_done;
    logic                  wr_en;
    logic                  wr_flg;
    logic                  wr_ctl;
    logic                  wr_cnt;
    logic                  tick_pulse;
    logic                  frc_step;
    logic                  frc_wrap;
    logic                  e64_pulse;
    logic                  edge_evt;
    logic                  gate_inhibit;
    logic                  count_inc;
    logic                  count_roll;
    logic [3:0]            flag_set;
    logic [3:0]            flag_clr;
    logic [7:0]            read_byte;

    // ************************************************************
    // APB slave: one wait state, write commits on the pready edge
    // ************************************************************
    assign sel     = ptpa_decode(paddr);
    assign wr_done = psel && penable && pwrite && pready_q;
    assign wr_en   = wr_done && sel.en;
    assign wr_flg  = wr_done && sel.flg;
    assign wr_ctl  = wr_done && sel.ctl;
    assign wr_cnt  = wr_done && sel.cnt;

    always_comb
    begin
        read_byte = 8'h00;
        if (sel.en)
            read_byte = irq_en_q & IRQ_EN_MASK;
        else if (sel.flg)
            read_byte = {flags_q, 4'h0};
        else if (sel.ctl)
            read_byte = pulse_accum_control_q;
        else if (sel.cnt)
            read_byte = count_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            apb_st_q  <= APB_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            case (apb_st_q)
                APB_IDLE:
                begin
                    if (psel && penable)
                    begin
                        apb_st_q  <= APB_ACK;
                        pready_q  <= 1'b1;
                        pslverr_q <= (sel == '0);
                        // Snapshot taken on a whole clock edge, so never mid-increment
                        if (pwrite)
                            prdata_q <= '0;
                        else if (sel.frc)
                            prdata_q <= {16'h0000, frc_q};
                        else
                            prdata_q <= {24'h000000, read_byte};
                    end
                end
                APB_ACK:
                begin
                    apb_st_q  <= APB_IDLE;
                    pready_q  <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default:
                begin
                    apb_st_q <= APB_IDLE;
                    pready_q <= 1'b0;
                end
            endcase
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            irq_en_q    <= IRQ_EN_RST;
            pulse_accum_control_q     <= PULSE_ACCUM_CONTROL_RST;
            boot_cnt_q  <= '0;
            pr_locked_q <= 1'b0;
        end
        else
        begin
            if (boot_cnt_q != BOOT_WINDOW)
                boot_cnt_q <= boot_cnt_q + 7'h01;
            // Normal modes: one prescaler write, only inside the boot window
            if (wr_en || boot_cnt_q == BOOT_WINDOW)
                pr_locked_q <= 1'b1;
            if (wr_en)
            begin
                irq_en_q[7:4] <= pwdata[7:4];
                if (!pr_locked_q || special_mode)
                    irq_en_q[1:0] <= pwdata[1:0];
            end
            if (wr_ctl)
                pulse_accum_control_q <= ptpa_pulse_accum_control_t'(pwdata[7:0]);
        end
    end

    // ************************************************************
    // Tick divider and free-running counter
    // ************************************************************
    // Chain never cleared by flag service, so periods stay exact
    always_ff @(posedge clk)
    begin
        if (!rstn)
            tick_div_q <= '0;
        else
            tick_div_q <= tick_div_q + 16'h0001;
    end

    assign tick_pulse = (tick_div_q & ptpa_tick_mask(pulse_accum_control_q.tick_rate_select))
                        == ptpa_tick_mask(pulse_accum_control_q.tick_rate_select);
    assign e64_pulse  = (tick_div_q[5:0] == E64_MASK);
    // Prescaler taps the low chain bits, apart from the tick rate path
    assign frc_step   = (tick_div_q[3:0] & ptpa_presc_mask(irq_en_q[1:0]))
                        == ptpa_presc_mask(irq_en_q[1:0]);
    assign frc_wrap   = frc_step && (frc_q == FRC_MAX);

    always_ff @(posedge clk)
    begin
        if (!rstn)
            frc_q <= '0;
        else if (frc_step)
            frc_q <= frc_q + 16'h0001;
    end

    // ************************************************************
    // Accumulator input synchroniser
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_s1_q   <= 1'b0;
            pin_s2_q   <= 1'b0;
            pin_s3_q   <= 1'b0;
            pin_lvl_q  <= 1'b0;
            pin_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q   <= accum_input_pin;
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            if (pin_s2_q == pin_s3_q)
                pin_lvl_q <= pin_s3_q;
            pin_prev_q <= pin_lvl_q;
        end
    end

    // ************************************************************
    // Pulse accumulator
    // ************************************************************
    // Edge select 0 picks falling edge, 1 rising edge
    assign edge_evt     = pulse_accum_control_q.accum_edge_select ? (pin_lvl_q && !pin_prev_q)
                                                    : (!pin_lvl_q && pin_prev_q);
    assign gate_inhibit = (pin_lvl_q == pulse_accum_control_q.accum_edge_select);
    assign count_inc    = pulse_accum_control_q.accum_enable &&
                          (pulse_accum_control_q.accum_mode_select ? (e64_pulse && !gate_inhibit)
                                                     : edge_evt);
    assign count_roll   = count_inc && (count_q == COUNT_MAX) && !wr_cnt;

    // No reset: contents survive system reset; a bus write wins over a count
    always_ff @(posedge clk)
    begin
        if (wr_cnt)
            count_q <= pwdata[7:0];
        else if (count_inc)
            count_q <= count_q + 8'h01;
    end

    // ************************************************************
    // Flags and interrupt request
    // ************************************************************
    assign flag_set = {frc_wrap, tick_pulse, count_roll, edge_evt};
    assign flag_clr = wr_flg ? pwdata[7:4] : 4'h0;
    // A new event in the clearing cycle stays set
    assign flags_d  = (flags_q & ~flag_clr) | flag_set;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            flags_q <= FLAGS_RST;
        else
            flags_q <= flags_d;
    end

    // Enables touch only the request path, never the flags
    always_ff @(posedge clk)
    begin
        if (!rstn)
            irq_q <= 1'b0;
        else
            irq_q <= |(flags_q & irq_en_q[7:4]);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cmp5_en_q <= 1'b1;
            cap4_en_q <= 1'b0;
        end
        else
        begin
            cmp5_en_q <= !pulse_accum_control_q.capture_compare_share_select;
            cap4_en_q <= pulse_accum_control_q.capture_compare_share_select;
        end
    end

    assign irq                     = irq_q;
    assign compare_channel_five_en = cmp5_en_q;
    assign capture_channel_four_en = cap4_en_q;
    assign port_bit7_direction     = pulse_accum_control_q.port_bit7_direction;
    assign port_bit3_direction     = pulse_accum_control_q.port_bit3_direction;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_tick_sets_flag: assert property (tick_pulse |=> flags_q[BIT_TICK - 4])
        else $error("tick timeout did not set tick flag");
    a_tick_first_period: assert property (
        $rose(flags_q[BIT_TICK - 4]) |-> $past(tick_div_q & ptpa_tick_mask(pulse_accum_control_q.tick_rate_select))
                                    == $past(ptpa_tick_mask(pulse_accum_control_q.tick_rate_select)))
        else $error("tick flag rose off a period boundary");
    a_flag_zero_keeps: assert property (
        wr_flg && !pwdata[BIT_TICK] && flags_q[BIT_TICK - 4] |=> flags_q[BIT_TICK - 4])
        else $error("zero write cleared tick flag");
    a_flag_one_clears: assert property (
        wr_flg && pwdata[BIT_ACC_EDGE] && !edge_evt |=> !flags_q[0])
        else $error("edge flag not cleared by write one");
    a_counter_wrap: assert property (
        frc_step && frc_q == FRC_MAX |=> frc_q == 16'h0000 && flags_q[3])
        else $error("counter wrap did not set overflow flag");
    a_irq_gating: assert property (##1 irq == $past(|(flags_q & irq_en_q[7:4])))
        else $error("interrupt request does not follow flag and enable");
    a_accum_rollover: assert property (count_roll |=> flags_q[1] && count_q == 8'h00)
        else $error("count rollover did not set overflow flag");
    a_gate_inhibit: assert property (
        pulse_accum_control_q.accum_mode_select && gate_inhibit |-> !count_inc)
        else $error("gated count advanced while inhibited");
    a_accum_disabled: assert property (!pulse_accum_control_q.accum_enable |-> !count_inc)
        else $error("count advanced while accumulator disabled");
    a_presc_locked: assert property (
        pr_locked_q && !special_mode && wr_en |=> $stable(irq_en_q[1:0]))
        else $error("prescaler changed after lock");
    a_apb_one_wait: assert property (
        psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("APB answer not one wait state");

    c_tick_flag:   cover property ($rose(flags_q[BIT_TICK - 4]));
    c_count_roll:  cover property (count_roll);
    c_edge_flag:   cover property (edge_evt && pulse_accum_control_q.accum_enable);
    c_gated_count: cover property (count_inc && pulse_accum_control_q.accum_mode_select);

endmodule

// File: tb/ptpa_pulse_src.sv
// Purpose: Model of the external signal source on the accumulator input pin.
// Assumes: The bench commands it through its tasks, one at a time.
// Notes:   Each level is held at least three bus cycles so the synchroniser sees it.
module ptpa_pulse_src (
    // Clock
    input  wire logic clk,
    // Driven pin
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'b0;

    task automatic level(input logic v);
        @(posedge clk);
        pin <= v;
    endtask

    // Each of the n pulses gives one edge of each kind, whatever the starting level
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            pin <= ~pin;
            repeat (3) @(posedge clk);
            pin <= ~pin;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// File: tb/ptpa_top_tb.sv
// Purpose: Self-checking bench for the tick generator and pulse accumulator.
// Assumes: APB slave with one wait state; rate codes 0 and 1 for the tick timing checks.
// Notes:   Tick and overflow checks are placed by cycles counted since reset release.
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
        end \
    end

module ptpa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ptpa_pkg::*;

    logic        clk = 1'b0;
    logic        rstn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        special_mode;
    logic        pin;
    logic        irq;
    logic        cmp5;
    logic        cap4;
    logic        dir7;
    logic        dir3;
    logic [31:0] rd;
    logic        err;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          guard = 0;

    ptpa_top uut (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accum_input_pin(pin), .special_mode(special_mode),
        .irq(irq), .compare_channel_five_en(cmp5), .capture_channel_four_en(cap4),
        .port_bit7_direction(dir7), .port_bit3_direction(dir3)
    );

    ptpa_pulse_src src (.clk(clk), .pin(pin));

    always #4 clk = ~clk;

    // ************************************************************
    // Cycle count since reset release, and hang guard
    // ************************************************************
    always @(posedge clk)
    begin
        guard++;
        cyc <= rstn ? cyc + 1 : 0;
        if (guard == 80000)
        begin
            err_total++;
            $display("unexpected timeout: run exceeded its cycle budget");
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the cycle guard ends a hung wait
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd[7:0] & m)
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        `CHK("irq", e, irq)
    endtask

    task automatic wait_cyc(input int n);
        while (cyc < n)
            @(posedge clk);
    endtask

    task automatic gchk(input logic [7:0] lo, input logic [7:0] hi);
        wr(OFS_COUNT, 8'h00);
        repeat (640) @(posedge clk);
        apb(1'b0, OFS_COUNT, 32'h0);
        `CHK("gated count in range", 1'b1, (rd[7:0] >= lo && rd[7:0] <= hi))
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        `CHK("compare5 enable", 1'b1, cmp5)
        wr(OFS_IRQ_EN, 8'h0C);
        rchk("irq enable", OFS_IRQ_EN, 8'hFF, 8'h00);
        wr(OFS_FLAGS, 8'h0F);
        rchk("flags", OFS_FLAGS, 8'hFF, 8'h00);
        rchk("control", OFS_PULSE_ACCUM_CONTROL, 8'hFF, 8'h00);
        wr(OFS_IRQ_EN, 8'h01);
        rchk("locked prescaler", OFS_IRQ_EN, 8'hFF, 8'h00);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h8C);
        // Control lands on the write edge, share enables one flop later
        repeat (2) @(posedge clk);
        `CHK("share outputs", 4'hE, {dir7, dir3, cap4, cmp5})
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h00);
    endtask

    task automatic t_event();
        wr(OFS_COUNT, 8'hFE);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h50);
        src.pulses(3);
        repeat (8) @(posedge clk);
        rchk("rising count", OFS_COUNT, 8'hFF, 8'h01);
        rchk("accum flags", OFS_FLAGS, 8'h30, 8'h30);
        irq_chk(1'b0);
        wr(OFS_IRQ_EN, 8'h20);
        irq_chk(1'b1);
        wr(OFS_FLAGS, 8'h20);
        rchk("after ovf clear", OFS_FLAGS, 8'h30, 8'h10);
        irq_chk(1'b0);
        wr(OFS_IRQ_EN, 8'h10);
        irq_chk(1'b1);
        wr(OFS_FLAGS, 8'h10);
        rchk("after edge clear", OFS_FLAGS, 8'h30, 8'h00);
        wr(OFS_IRQ_EN, 8'h00);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h40);
        src.pulses(2);
        repeat (8) @(posedge clk);
        rchk("falling count", OFS_COUNT, 8'hFF, 8'h02);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h10);
        src.pulses(2);
        repeat (8) @(posedge clk);
        rchk("disabled count", OFS_COUNT, 8'hFF, 8'h02);
    endtask

    task automatic t_gated();
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h60);
        gchk(8'd0, 8'd0);
        src.level(1'b1);
        repeat (6) @(posedge clk);
        gchk(8'd9, 8'd11);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h70);
        gchk(8'd0, 8'd0);
        src.level(1'b0);
        repeat (6) @(posedge clk);
        gchk(8'd9, 8'd11);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h00);
        wr(OFS_FLAGS, 8'h30);
    endtask

    task automatic t_tick();
        wait_cyc(8150);
        rchk("tick early", OFS_FLAGS, 8'h40, 8'h00);
        wait_cyc(8250);
        rchk("tick first", OFS_FLAGS, 8'h40, 8'h40);
        wr(OFS_FLAGS, 8'h00);
        rchk("tick kept", OFS_FLAGS, 8'h40, 8'h40);
        wr(OFS_IRQ_EN, 8'h40);
        irq_chk(1'b1);
        wr(OFS_FLAGS, 8'h40);
        rchk("tick cleared", OFS_FLAGS, 8'h40, 8'h00);
        irq_chk(1'b0);
        wait_cyc(16300);
        rchk("tick second early", OFS_FLAGS, 8'h40, 8'h00);
        wait_cyc(16450);
        rchk("tick second", OFS_FLAGS, 8'h40, 8'h40);
        wr(OFS_IRQ_EN, 8'h00);
        wr(OFS_PULSE_ACCUM_CONTROL, 8'h01);
        wr(OFS_FLAGS, 8'h40);
        wait_cyc(24700);
        rchk("rate 1 skip", OFS_FLAGS, 8'h40, 8'h00);
        wait_cyc(32900);
        rchk("rate 1 tick", OFS_FLAGS, 8'h40, 8'h40);
    endtask

    task automatic t_late();
        wait_cyc(65450);
        rchk("overflow early", OFS_FLAGS, 8'h80, 8'h00);
        wait_cyc(65600);
        rchk("overflow", OFS_FLAGS, 8'h80, 8'h80);
        wr(OFS_IRQ_EN, 8'h80);
        irq_chk(1'b1);
        wr(OFS_FLAGS, 8'h80);
        irq_chk(1'b0);
        special_mode <= 1'b1;
        wr(OFS_IRQ_EN, 8'h01);
        rchk("special prescaler", OFS_IRQ_EN, 8'hFF, 8'h01);
        special_mode <= 1'b0;
        wr(OFS_COUNT, 8'h5A);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rchk("count through reset", OFS_COUNT, 8'hFF, 8'h5A);
        rchk("control after reset", OFS_PULSE_ACCUM_CONTROL, 8'hFF, 8'h00);
    endtask

    initial
    begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        special_mode = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_event();
        t_gated();
        t_tick();
        t_late();
        summarize();
    end
endmodule
